// ==== led_shutdown_ctrl.sv ====
// Shutdown modes and spread spectrum control of the LED driver
// Behaviour
// - Range select field picks one of four spread widths, narrowest to widest.
// - Registers keep their contents in either shutdown mode.
// - Soft shutdown bit cleared enters software shutdown, all sources off.
// - Register access works normally during software shutdown.
// - Shutdown pin low forces hardware shutdown, sources disabled.
// - Shutdown pin high again resumes outputs from retained settings.
// - Pin rising edge resets serial interface state, registers untouched.
// - Register access works while shutdown pin is low.
// - Soft shutdown bit resets to zero; host must write one.
`include "led_shutdown_regs.svh"
module led_shutdown_ctrl
	import led_shutdown_pkg::*;
(
	input  wire logic          clk,
	input  wire logic          arst_n,
	input  wire logic          shutdown_pin_n,
	input  wire reg_req_s      req,
	output logic        [7:0]  rdata,
	output logic               rvalid,
	output logic               spi_reset,
	output logic               current_enable,
	output spread_range_e      spread_range_select
);
	// Pin synchroniser and edge detector
	logic          pin_meta_q;
	logic          pin_meta_d;
	logic          pin_sync_q;
	logic          pin_sync_d;
	logic          pin_prev_q;
	logic          pin_prev_d;
	logic          pin_rise;
	// Register file
	logic          sel_ctrl;
	logic          sel_spread;
	logic [7:0]    ctrl_q;
	logic [7:0]    ctrl_d;
	logic [7:0]    spread_q;
	logic [7:0]    spread_d;
	// Output stage
	logic [7:0]    rdata_d;
	logic          rvalid_d;
	logic          spi_reset_d;
	logic          enable_d;
	spread_range_e range_d;

	// Two flip-flops before the pin is used anywhere
	always_comb
	begin
		pin_meta_d = shutdown_pin_n;
		pin_sync_d = pin_meta_q;
		pin_prev_d = pin_sync_q;
		pin_rise = pin_sync_q && !pin_prev_q;
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			pin_meta_q <= 1'b0;
			pin_sync_q <= 1'b0;
			pin_prev_q <= 1'b0;
		end
		else
		begin
			pin_meta_q <= pin_meta_d;
			pin_sync_q <= pin_sync_d;
			pin_prev_q <= pin_prev_d;
		end
	end

	// Address decode and writes, accepted in every mode
	always_comb
	begin
		sel_ctrl = 1'b0;
		sel_spread = 1'b0;
		if (req.addr == `MAIN_CONTROL_ADDR)
		begin
			sel_ctrl = 1'b1;
		end
		else if (req.addr == `SPREAD_SETUP_ADDR)
		begin
			sel_spread = 1'b1;
		end
		ctrl_d = ctrl_q;
		spread_d = spread_q;
		if (req.wr && sel_ctrl)
		begin
			ctrl_d = req.wdata;
		end
		if (req.wr && sel_spread)
		begin
			spread_d = req.wdata;
		end
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			ctrl_q <= `MAIN_CONTROL_RESET;
			spread_q <= `SPREAD_SETUP_RESET;
		end
		else
		begin
			ctrl_q <= ctrl_d;
			spread_q <= spread_d;
		end
	end

	// Read answer; data holds until the next read
	always_comb
	begin
		rvalid_d = req.rd;
		rdata_d = rdata;
		if (req.rd && sel_ctrl)
		begin
			rdata_d = ctrl_q;
		end
		else if (req.rd && sel_spread)
		begin
			rdata_d = spread_q;
		end
		else if (req.rd)
		begin
			rdata_d = 8'h00;
		end
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			rdata <= 8'h00;
			rvalid <= 1'b0;
		end
		else
		begin
			rdata <= rdata_d;
			rvalid <= rvalid_d;
		end
	end

	// Sources need both the soft bit and the synced pin high
	always_comb
	begin
		spi_reset_d = pin_rise;
		enable_d = 1'b1;
		if (!ctrl_q[`SOFT_SHUTDOWN_POS])
		begin
			enable_d = 1'b0;
		end
		if (!pin_sync_q)
		begin
			enable_d = 1'b0;
		end
		range_d = spread_range_e'(spread_q[`SPREAD_RANGE_LSB +: 2]);
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			spi_reset <= 1'b0;
			current_enable <= 1'b0;
			spread_range_select <= SPREAD_5;
		end
		else
		begin
			spi_reset <= spi_reset_d;
			current_enable <= enable_d;
			spread_range_select <= range_d;
		end
	end

	a_enable_needs_both: assert property (
		@(posedge clk) disable iff (!arst_n)
		current_enable |-> $past(ctrl_q[`SOFT_SHUTDOWN_POS] & pin_sync_q))
		else $error("current enabled without both conditions");
	a_soft_off: assert property (
		@(posedge clk) disable iff (!arst_n)
		!ctrl_q[`SOFT_SHUTDOWN_POS] |=> !current_enable)
		else $error("current on in software shutdown");
	a_pin_low_off: assert property (
		@(posedge clk) disable iff (!arst_n)
		!shutdown_pin_n [*3] |=> !current_enable)
		else $error("current on while pin low");
	a_pin_low_hold: assert property (
		@(posedge clk) disable iff (!arst_n)
		!pin_sync_q |=> !current_enable)
		else $error("current on while synced pin low");
	a_pin_resume: assert property (
		@(posedge clk) disable iff (!arst_n)
		(shutdown_pin_n && ctrl_q[`SOFT_SHUTDOWN_POS]) [*4] |-> current_enable)
		else $error("outputs not resumed");
	a_spi_reset_edge: assert property (
		@(posedge clk) disable iff (!arst_n)
		$rose(pin_sync_q) |=> spi_reset ##1 !spi_reset)
		else $error("serial reset pulse wrong");
	a_spi_reset_single: assert property (
		@(posedge clk) disable iff (!arst_n)
		spi_reset |=> !spi_reset)
		else $error("serial reset pulse too long");
	a_reset_keeps_regs: assert property (
		@(posedge clk) disable iff (!arst_n)
		spi_reset && !req.wr |=> $stable(ctrl_q) && $stable(spread_q))
		else $error("registers changed without write");
	a_unmapped_ignored: assert property (
		@(posedge clk) disable iff (!arst_n)
		req.wr && req.addr != `MAIN_CONTROL_ADDR
		&& req.addr != `SPREAD_SETUP_ADDR |=> $stable(ctrl_q) && $stable(spread_q))
		else $error("unmapped write changed a register");
	a_write_in_shutdown: assert property (
		@(posedge clk) disable iff (!arst_n)
		req.wr && req.addr == `MAIN_CONTROL_ADDR |=> ctrl_q == $past(req.wdata))
		else $error("write lost");
	a_spread_write: assert property (
		@(posedge clk) disable iff (!arst_n)
		req.wr && req.addr == `SPREAD_SETUP_ADDR |=> spread_q == $past(req.wdata))
		else $error("spread write lost");
	a_read_answer: assert property (
		@(posedge clk) disable iff (!arst_n)
		req.rd && req.addr == `SPREAD_SETUP_ADDR && !$past(req.wr)
		|=> rvalid && rdata == $past(spread_q))
		else $error("read answer wrong");
	a_read_control: assert property (
		@(posedge clk) disable iff (!arst_n)
		req.rd && req.addr == `MAIN_CONTROL_ADDR |=> rdata == $past(ctrl_q))
		else $error("control read answer wrong");
	a_no_stray_valid: assert property (
		@(posedge clk) disable iff (!arst_n)
		!req.rd |=> !rvalid)
		else $error("read valid without read");
	a_range_follows: assert property (
		@(posedge clk) disable iff (!arst_n)
		1'b1 |=> spread_range_select == spread_range_e'($past(spread_q[1:0])))
		else $error("range select wrong");

	c_soft_shutdown: cover property (@(posedge clk) $fell(current_enable));
	c_pin_rise: cover property (@(posedge clk) spi_reset);
	c_enable_on: cover property (@(posedge clk) $rose(current_enable));
	c_widest: cover property (@(posedge clk) spread_range_select == SPREAD_34);
endmodule

// ==== led_shutdown_regs.svh ====
// Register offsets, field positions and reset values
`ifndef LED_SHUTDOWN_REGS_SVH
`define LED_SHUTDOWN_REGS_SVH
`define MAIN_CONTROL_ADDR     8'h00
`define SPREAD_SETUP_ADDR     8'h19
`define SOFT_SHUTDOWN_POS     0
`define SPREAD_RANGE_LSB      0
`define MAIN_CONTROL_RESET    8'h00
`define SPREAD_SETUP_RESET    8'h00
`endif

// ==== led_shutdown_pkg.sv ====
// Types for the shutdown and spread control block
package led_shutdown_pkg;
	typedef enum logic [1:0] {
		SPREAD_5  = 2'b00,
		SPREAD_15 = 2'b01,
		SPREAD_24 = 2'b10,
		SPREAD_34 = 2'b11
	} spread_range_e;
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_req_s;
endpackage

// ==== led_host_model.sv ====
// Host model driving register requests and the shutdown pin
module led_host_model
	import led_shutdown_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rvalid,
	input  wire logic [7:0] rdata,
	output reg_req_s        req,
	output logic            pin_n
);
	timeunit 1ns;
	timeprecision 1ns;
	initial
	begin
		req = '0;
		pin_n = 1'b0;
	end
	// One request pulse, then for a read a bounded wait for read data
	task automatic access(input logic w, input logic [7:0] a, d,
		output logic [7:0] q, output logic ok);
		@(negedge clk) req <= {w, !w, a, d};
		@(negedge clk) req <= '0;
		q = 8'h00;
		ok = w;
		for (int i = 0; i < 4 && !w; i++)
		begin
			if (rvalid)
			begin
				q = rdata;
				ok = 1'b1;
				break;
			end
			@(negedge clk);
		end
	endtask
	// Pin level changes at the falling edge
	task automatic drive_pin(input logic lvl);
		@(negedge clk) pin_n = lvl;
	endtask
endmodule

// ==== tb_led_shutdown_ctrl.sv ====
// Testbench for the shutdown and spread control block
module tb_led_shutdown_ctrl
	import led_shutdown_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic          clk = 1'b0;
	logic          arst_n = 1'b0;
	logic [7:0]    rdata, q, v;
	logic          rvalid, spi_reset, current_enable, pin_n;
	spread_range_e spread_range_select;
	reg_req_s      req;
	int            err_total = 0;
	int            compares = 0;
	int            pulses;
	always #50 clk = ~clk;
	led_host_model led_host_model_inst (.clk(clk), .rvalid(rvalid),
		.rdata(rdata), .req(req), .pin_n(pin_n));
	led_shutdown_ctrl led_shutdown_ctrl_inst (.clk(clk), .arst_n(arst_n),
		.shutdown_pin_n(pin_n), .req(req), .rdata(rdata), .rvalid(rvalid),
		.spi_reset(spi_reset), .current_enable(current_enable),
		.spread_range_select(spread_range_select));
	function automatic logic exp_en(input logic ctrl, pin);
		return ctrl & pin;
	endfunction
	task automatic check(input logic [7:0] seen, exp);
		compares++;
		if (seen !== exp)
		begin
			err_total++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic complete_run;
		$display("errors %0d compares %0d", err_total, compares);
		if (err_total == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic rw(input logic w, input logic [7:0] a, d);
		logic ok;
		led_host_model_inst.access(w, a, d, q, ok);
		if (!ok)
		begin
			err_total++;
			$display("mismatch at %0t: no read answer", $time);
		end
		repeat (3) @(negedge clk);
	endtask
	task automatic set_pin(input logic lvl);
		pulses = 0;
		led_host_model_inst.drive_pin(lvl);
		for (int i = 0; i < 6; i++)
		begin
			@(negedge clk) pulses += spi_reset;
		end
	endtask
	initial
	begin
		#5000000 err_total++;
		complete_run;
	end
	initial
	begin
		void'($urandom(91452));
		repeat (10) @(negedge clk);
		arst_n = 1'b1;
		check(current_enable, 8'h00);
		rw(1'b0, 8'h00, 8'h00);
		check(q, 8'h00);
		set_pin(1'b1);
		check(8'(pulses), 8'h01);
		rw(1'b1, 8'h00, 8'h01);
		check(current_enable, exp_en(1'b1, 1'b1));
		for (int k = 0; k < 4; k++)
		begin
			v = {6'($urandom), 2'(k)};
			rw(1'b1, 8'h19, v);
			check(spread_range_select, v[1:0]);
			rw(1'b0, 8'h19, 8'h00);
			check(q, v);
		end
		set_pin(1'b0);
		check(current_enable, exp_en(1'b1, 1'b0));
		check(8'(pulses), 8'h00);
		rw(1'b0, 8'h00, 8'h00);
		check(q, 8'h01);
		rw(1'b1, 8'h19, 8'h03);
		rw(1'b0, 8'h19, 8'h00);
		check(q, 8'h03);
		rw(1'b1, 8'h00, 8'h01);
		set_pin(1'b1);
		check(8'(pulses), 8'h01);
		check(current_enable, exp_en(1'b1, 1'b1));
		rw(1'b1, 8'h00, 8'h00);
		check(current_enable, 8'h00);
		rw(1'b1, 8'h7F, 8'hFF);
		rw(1'b0, 8'h19, 8'h00);
		check(q, 8'h03);
		rw(1'b0, 8'h7F, 8'h00);
		check(q, 8'h00);
		complete_run;
	end
endmodule
